// ---- hdl/dpb_pkg.sv ----
// Shared constants for the host-side port controller of a two-port memory.
// Assumes a 20 MHz system clock; all pin timing is counted in its cycles.
package dpb_pkg;
    localparam int CLK_PERIOD_NS        = 50;
    // Pin timing figures in ns
    localparam int WRITE_PULSE_MIN_NS   = 35;  // Slower grade least pulse
    localparam int WRITE_TO_FLOAT_NS    = 20;
    localparam int DATA_SETUP_NS        = 25;
    localparam int WRITE_HOLD_CONT_NS   = 25;
    localparam int WRITE_TO_DATA_NS     = 70;
    localparam int FLAG_CLEAR_NS        = 35;
    // Least times round up to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int PULSE_WIDE_NS = (WRITE_TO_FLOAT_NS + DATA_SETUP_NS > WRITE_PULSE_MIN_NS)
                                 ? WRITE_TO_FLOAT_NS + DATA_SETUP_NS : WRITE_PULSE_MIN_NS;
    localparam int WP_CYC_OE_OFF   = cyc_up(WRITE_PULSE_MIN_NS);
    localparam int WP_CYC_OE_ON    = cyc_up(PULSE_WIDE_NS);
    localparam int HOLD_CYC        = cyc_up(WRITE_HOLD_CONT_NS);
    localparam int READ_WAIT_CYC   = cyc_up(WRITE_TO_DATA_NS);
    localparam int FLAG_WAIT_CYC   = cyc_up(FLAG_CLEAR_NS);
    localparam int SYNC_CYC        = 2;  // Two-flop lag on every pin input
    localparam int CNT_W           = 4;
    // Reset values of the pin drivers (all strobes idle high)
    localparam logic RST_STROBE    = 1'b1;

    typedef enum logic [2:0] {
        DPB_IDLE  = 3'b000,
        DPB_SETUP = 3'b001,
        DPB_PULSE = 3'b010,
        DPB_HOLD  = 3'b011,
        DPB_READ  = 3'b100,
        DPB_DONE  = 3'b101
    } dpb_state_e;
endpackage

// ---- hdl/dpb_sync_if.sv ----
// Carrier for the synchronised pin inputs between sync stage and controller.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface dpb_sync_if #(parameter int DW = 16);
    logic [DW-1:0] data;
    logic          busy_n;
    logic          flag_n;
    modport src (output data, output busy_n, output flag_n);
    modport dst (input data, input busy_n, input flag_n);
endinterface

// ---- hdl/dpb_sync.sv ----
// Two-flop synchronisers for the memory pins that enter the clock domain.
// Assumes the pins change freely with respect to clk.
`timescale 1ns/1ps
module dpb_sync #(
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Raw pins
    input  wire logic [DW-1:0] data_pin,
    input  wire logic          busy_pin_n,
    input  wire logic          flag_pin_n,
    // Synchronised side
    dpb_sync_if.src            out
);
    logic [DW+1:0] s1_q;
    logic [DW+1:0] s2_q;
    logic [DW+1:0] s1_d;
    logic [DW+1:0] s2_d;

    // First stage feeds only the second
    always_comb begin
        s1_d = {busy_pin_n, flag_pin_n, data_pin};
        s2_d = s1_q;
    end

    // Register both stages; idle level is high for strobes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {2'b11, {DW{1'b0}}};
            s2_q <= {2'b11, {DW{1'b0}}};
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign out.data   = s2_q[DW-1:0];
    assign out.flag_n = s2_q[DW];
    assign out.busy_n = s2_q[DW+1];
endmodule

// ---- hdl/dpb_host.sv ----
// Host controller driving one port of an asynchronous two-port memory.
// Assumes the memory pins are wired directly; bus resolution is outside.
`timescale 1ns/1ps
// Overview of operation
// - Address moves only while write strobe and port select are both high.
// - Host drives no write data while memory outputs may still be on.
// - Write pulse stretched to float plus setup when output enable low.
// - Memory access: select low, flag select high, byte selects per lane.
// - After busy release, write is held at least the hold-after-contention time.
// - Flag access: port select high, flag select low.
module dpb_host
    import dpb_pkg::*;
#(
    parameter int AW = 13,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // User request
    input  wire logic          req,
    input  wire logic          req_write,
    input  wire logic          req_flag,
    input  wire logic [1:0]    req_lanes,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               ack,
    output logic [DW-1:0]      rdata,
    output logic               irq_seen,
    // Memory pins
    output logic [AW-1:0]      mem_addr,
    output logic               port_select_n,
    output logic               flag_select_n,
    output logic               rw_n,
    output logic               out_enable_n,
    output logic               high_byte_select_n,
    output logic               low_byte_select_n,
    input  wire logic [DW-1:0] data_in,
    output logic [DW-1:0]      data_out,
    output logic               data_oe_n,
    input  wire logic          busy_in_n,
    input  wire logic          int_in_n
);
    // Refuse widths and counts the sequencer cannot serve
    if (AW < 1 || DW < 2 || DW % 2 != 0 || READ_WAIT_CYC + SYNC_CYC >= 2**CNT_W) begin : g_bad
        $error("dpb_host: unsupported widths");
    end

    dpb_sync_if #(.DW(DW)) syn ();

    dpb_sync #(.DW(DW)) u_sync (
        .clk        (clk),
        .rst_n      (rst_n),
        .data_pin   (data_in),
        .busy_pin_n (busy_in_n),
        .flag_pin_n (int_in_n),
        .out        (syn)
    );

    dpb_state_e          st_q, st_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [AW-1:0]       addr_q, addr_d;
    logic                sel_q, sel_d, fsel_q, fsel_d, rw_q, rw_d, oe_q, oe_d;
    logic                hb_q, hb_d, lb_q, lb_d;
    logic [DW-1:0]       wd_q, wd_d, rd_q, rd_d;
    logic                doe_q, doe_d, ack_q, ack_d, irq_q, irq_d, wr_q, wr_d;

    // Sequencer: next pin and state values
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        addr_d = addr_q;
        sel_d  = sel_q;
        fsel_d = fsel_q;
        rw_d   = rw_q;
        oe_d   = oe_q;
        hb_d   = hb_q;
        lb_d   = lb_q;
        wd_d   = wd_q;
        rd_d   = rd_q;
        doe_d  = doe_q;
        wr_d   = wr_q;
        ack_d  = 1'b0;
        irq_d  = ~syn.flag_n;
        case (st_q)
            DPB_IDLE: begin
                if (req) begin
                    // Port and flag selects, write strobe and output enable are all high here, address may move
                    addr_d = req_addr;
                    wd_d   = req_wdata;
                    wr_d   = req_write;
                    hb_d   = ~req_lanes[1];
                    lb_d   = ~req_lanes[0];
                    oe_d   = req_write;  // Outputs off for writes
                    st_d   = DPB_SETUP;
                end
            end
            DPB_SETUP: begin
                // Strobe and select fall on the same edge; outputs are already off, so memory data stays floating
                if (wr_q) begin
                    rw_d  = 1'b0;
                    doe_d = 1'b0;
                    cnt_d = CNT_W'(WP_CYC_OE_OFF);
                end else begin
                    // Data delay plus the synchroniser lag on the data pins
                    cnt_d = CNT_W'(READ_WAIT_CYC + SYNC_CYC);
                end
                if (req_flag) begin
                    fsel_d = 1'b0;
                end else begin
                    sel_d = 1'b0;
                end
                st_d = wr_q ? DPB_PULSE : DPB_READ;
            end
            DPB_PULSE: begin
                // Busy low holds the write open until it releases
                if (!syn.busy_n) begin
                    cnt_d = CNT_W'(HOLD_CYC);
                end else if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else begin
                    st_d  = DPB_HOLD;
                    rw_d  = 1'b1;
                    sel_d = 1'b1;
                    fsel_d = 1'b1;
                end
            end
            DPB_HOLD: begin
                // Data held one cycle after strobes rise
                doe_d = 1'b1;
                st_d  = DPB_DONE;
            end
            DPB_READ: begin
                oe_d = 1'b0;
                // Wait on busy, then the data delay
                if (!syn.busy_n) begin
                    cnt_d = CNT_W'(READ_WAIT_CYC + SYNC_CYC);
                end else if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else begin
                    rd_d   = syn.data;
                    sel_d  = 1'b1;
                    fsel_d = 1'b1;
                    oe_d   = 1'b1;
                    st_d   = DPB_DONE;
                end
            end
            DPB_DONE: begin
                ack_d = 1'b1;
                st_d  = DPB_IDLE;
            end
            default: st_d = DPB_IDLE;
        endcase
    end

    // Register everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= DPB_IDLE;
            cnt_q  <= '0;
            addr_q <= '0;
            sel_q  <= RST_STROBE;
            fsel_q <= RST_STROBE;
            rw_q   <= RST_STROBE;
            oe_q   <= RST_STROBE;
            hb_q   <= RST_STROBE;
            lb_q   <= RST_STROBE;
            wd_q   <= '0;
            rd_q   <= '0;
            doe_q  <= RST_STROBE;
            wr_q   <= 1'b0;
            ack_q  <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            addr_q <= addr_d;
            sel_q  <= sel_d;
            fsel_q <= fsel_d;
            rw_q   <= rw_d;
            oe_q   <= oe_d;
            hb_q   <= hb_d;
            lb_q   <= lb_d;
            wd_q   <= wd_d;
            rd_q   <= rd_d;
            doe_q  <= doe_d;
            wr_q   <= wr_d;
            ack_q  <= ack_d;
            irq_q  <= irq_d;
        end
    end

    // Pins straight from flops
    assign mem_addr           = addr_q;
    assign port_select_n      = sel_q;
    assign flag_select_n      = fsel_q;
    assign rw_n               = rw_q;
    assign out_enable_n       = oe_q;
    assign high_byte_select_n = hb_q;
    assign low_byte_select_n  = lb_q;
    assign data_out           = wd_q;
    assign data_oe_n          = doe_q;
    assign ack                = ack_q;
    assign rdata              = rd_q;
    assign irq_seen           = irq_q;

    a_addr_stable: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(addr_q) |-> $past(rw_q) && $past(sel_q))
        else $error("address moved during access");
    a_write_overlap: assert property (@(posedge clk) disable iff (!rst_n)
        (!rw_q && !sel_q) |-> st_q == DPB_PULSE || st_q == DPB_HOLD)
        else $error("write overlap outside pulse");
    a_sel_after_rw: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sel_q) && wr_q |-> !rw_q)
        else $error("select fell before write strobe");
    a_no_drive_oe: assert property (@(posedge clk) disable iff (!rst_n)
        !doe_q |-> oe_q)
        else $error("data driven while outputs on");
    a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(rw_q) |-> cnt_q == CNT_W'(oe_q ? WP_CYC_OE_OFF : WP_CYC_OE_ON))
        else $error("write pulse too short");
    a_flag_access: assert property (@(posedge clk) disable iff (!rst_n)
        !fsel_q |-> sel_q)
        else $error("flag and memory select together");
    a_busy_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == DPB_PULSE && !syn.busy_n |=> st_q == DPB_PULSE && !rw_q)
        else $error("write not held after busy");
    a_read_wait: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sel_q) && !wr_q |-> !sel_q [*4])
        else $error("read ended too early");
endmodule

// ---- test/dpb_mem_model.sv ----
// Behavioural model of one port of the two-port memory, in the slave role.
// Assumes the host pins are registered on clk; the bench plays the far port.
`timescale 1ns/1ps
module dpb_mem_model #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    // Clock for the floating-bus pattern
    input  wire logic          clk,
    // Host pins
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic          port_select_n,
    input  wire logic          flag_select_n,
    input  wire logic          rw_n,
    input  wire logic          out_enable_n,
    input  wire logic          high_byte_select_n,
    input  wire logic          low_byte_select_n,
    input  wire logic [DW-1:0] data_out,
    input  wire logic          data_oe_n,
    output logic      [DW-1:0] data_in,
    output logic               busy_n,
    output logic               int_n,
    // Far port stand-ins
    input  wire logic          contend,
    input  wire logic          int_set,
    output logic               clash
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd;
    logic [DW-1:0] last;
    logic          flag_q;
    logic          ram_sel;
    logic          flag_sel;
    initial begin
        flag_q = 1'b1;
        last  = '0;
    end
    // Far port claimed the location first; busy only mirrors it here
    assign busy_n = ~contend;
    assign #35 int_n = ~int_set;
    assign ram_sel = !port_select_n && flag_select_n;
    assign flag_sel = port_select_n && !flag_select_n;
    // Outputs turn on only for reads; a write keeps them floating
    assign rd = flag_sel ? {{(DW-1){1'b1}}, flag_q} : mem[mem_addr];
    assign clash = rw_n && !out_enable_n && (ram_sel || flag_sel) && !data_oe_n;
    // A released bus shows the inverse of the last word the memory drove
    assign data_in = !data_oe_n ? data_out
                   : ((rw_n && !out_enable_n && (ram_sel || flag_sel)) ? rd : ~last);
    always @(posedge clk) begin
        if (rw_n && !out_enable_n && (ram_sel || flag_sel)) begin
            last <= rd;
        end
    end
    // Write only in the overlap of select and strobe, held off while busy
    always @(*) begin
        if (!rw_n && busy_n && ram_sel && !high_byte_select_n) begin
            mem[mem_addr][DW-1:DW/2] = data_out[DW-1:DW/2];
        end
        if (!rw_n && busy_n && ram_sel && !low_byte_select_n) begin
            mem[mem_addr][DW/2-1:0] = data_out[DW/2-1:0];
        end
        if (!rw_n && busy_n && flag_sel) begin
            flag_q = data_out[0];
        end
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the host port controller against a memory model.
// Assumes inputs change on the falling edge and the model plays the device.
`timescale 1ns/1ps
module tb;
    import dpb_pkg::*;
    localparam int AW = 4;
    localparam int DW = 16;
    localparam int LIMIT = 3000;
    logic          clk, rst_n, req, req_write, req_flag, ack, irq_seen, contend, int_set;
    logic          port_select_n, flag_select_n, rw_n, out_enable_n, clash, busy_in_n;
    logic          high_byte_select_n, low_byte_select_n, data_oe_n, int_in_n;
    logic [1:0]    req_lanes;
    logic [AW-1:0] req_addr, mem_addr, pa;
    logic [DW-1:0] req_wdata, rdata, data_in, data_out;
    logic          pw;
    int            n_fail, samples_checked, cycles, wc, n;

    dpb_host #(.AW(AW), .DW(DW)) dpb_host_inst (.clk(clk), .rst_n(rst_n), .req(req),
        .req_write(req_write), .req_flag(req_flag), .req_lanes(req_lanes),
        .req_addr(req_addr), .req_wdata(req_wdata), .ack(ack), .rdata(rdata),
        .irq_seen(irq_seen), .mem_addr(mem_addr), .port_select_n(port_select_n),
        .flag_select_n(flag_select_n), .rw_n(rw_n), .out_enable_n(out_enable_n),
        .high_byte_select_n(high_byte_select_n), .low_byte_select_n(low_byte_select_n),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .busy_in_n(busy_in_n), .int_in_n(int_in_n));
    dpb_mem_model #(.AW(AW), .DW(DW)) dpb_mem_model_inst (.clk(clk), .mem_addr(mem_addr),
        .port_select_n(port_select_n), .flag_select_n(flag_select_n), .rw_n(rw_n),
        .out_enable_n(out_enable_n), .high_byte_select_n(high_byte_select_n),
        .low_byte_select_n(low_byte_select_n), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .busy_n(busy_in_n), .int_n(int_in_n), .contend(contend),
        .int_set(int_set), .clash(clash));

    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One access: request for one cycle, fields held until ack
    task automatic access(input logic w, input logic f, input logic [1:0] ln,
                          input logic [AW-1:0] a, input logic [DW-1:0] d, input int lim);
        @(negedge clk);
        req = 1'b1;
        req_write = w;
        req_flag = f;
        req_lanes = ln;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (ack !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("ack", DW'(n < lim), 1);
    endtask
    // Back-to-back writes then reads of whole words
    task automatic run_words();
        access(1, 0, 2'h3, 4'h3, 16'hA55A, 12);
        access(1, 0, 2'h3, 4'h4, 16'h5AA5, 12);
        access(0, 0, 2'h3, 4'h3, 16'h0000, 12);
        check("rd3", rdata, 16'hA55A);
        access(0, 0, 2'h3, 4'h4, 16'h0000, 12);
        check("rd4", rdata, 16'h5AA5);
    endtask
    // Byte lanes one at a time, and none at all
    task automatic run_lanes();
        access(1, 0, 2'h3, 4'h6, 16'h1234, 12);
        access(1, 0, 2'h2, 4'h6, 16'hABCD, 12);
        access(0, 0, 2'h3, 4'h6, 16'h0000, 12);
        check("upper", rdata, 16'hAB34);
        access(1, 0, 2'h1, 4'h6, 16'h5678, 12);
        access(1, 0, 2'h0, 4'h6, 16'hFFFF, 12);
        access(0, 0, 2'h3, 4'h6, 16'h0000, 12);
        check("lower", rdata, 16'hAB78);
    endtask
    // Flag access leaves the word at the same address alone
    task automatic run_flag();
        access(1, 1, 2'h3, 4'h6, 16'h0000, 12);
        access(0, 1, 2'h3, 4'h6, 16'h0000, 12);
        check("flag0", rdata, 16'hFFFE);
        access(1, 1, 2'h3, 4'h6, 16'hFFFF, 12);
        access(0, 1, 2'h3, 4'h6, 16'h0000, 12);
        check("flag1", rdata, 16'hFFFF);
        access(0, 0, 2'h3, 4'h6, 16'h0000, 12);
        check("ram6", rdata, 16'hAB78);
    endtask
    // Write under contention: held off, then completed after release
    task automatic run_busy();
        access(1, 0, 2'h3, 4'h2, 16'h1111, 12);
        @(negedge clk);
        contend = 1'b1;
        repeat (3) @(negedge clk);
        fork
            begin
                repeat (10) @(negedge clk);
                check("inhibit", dpb_mem_model_inst.mem[2], 16'h1111);
                contend = 1'b0;
            end
            access(1, 0, 2'h3, 4'h2, 16'h0F0F, 40);
        join
        check("stall", DW'(n >= 10), 1);
        access(0, 0, 2'h3, 4'h2, 16'h0000, 12);
        check("after", rdata, 16'h0F0F);
    endtask
    // Interrupt pin seen when set and gone when cleared
    task automatic run_irq();
        @(negedge clk);
        check("irq_idle", DW'(irq_seen), 0);
        int_set = 1'b1;
        repeat (5) @(negedge clk);
        check("irq_set", DW'(irq_seen), 1);
        int_set = 1'b0;
        repeat (5) @(negedge clk);
        check("irq_clr", DW'(irq_seen), 0);
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pin watch on the quiet edge: address steady in writes, no bus fight, pulse width
    always @(negedge clk) begin
        pa <= mem_addr;
        pw <= !rw_n && !port_select_n;
        wc <= !rw_n ? wc + 1 : 0;
        if (rst_n) begin
            check("clash", DW'(clash), 0);
            if (pa !== mem_addr) check("addr", DW'(pw && !rw_n && !port_select_n), 0);
            if (rw_n && wc != 0) begin
                check("pulse",
                      DW'(wc >= (out_enable_n ? WP_CYC_OE_OFF : WP_CYC_OE_ON)), 1);
            end
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        {rst_n, req, req_write, req_flag, contend, int_set} = '0;
        {req_lanes, req_addr, req_wdata, pa, pw, wc} = '0;
        {n_fail, samples_checked, cycles, n} = '0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        run_words();
        run_lanes();
        run_flag();
        run_busy();
        run_irq();
        give_verdict();
    end
endmodule
